// File: verilog/aox_pkg.sv
// package: constants and types for the accumulator or/xor datapath
package aox_pkg;
	localparam int          ACC_W        = 32;
	localparam int          WORD_W       = 16;
	localparam int          ADDR_W       = 16;
	localparam int          STACK_DEPTH  = 8;
	localparam int          CNT_W        = 6;
	localparam logic [5:0]  RANGE_MIN    = 6'h01;
	localparam logic [5:0]  RANGE_MAX    = 6'h20;
	localparam logic [31:0] ACC_RESET    = 32'h0000_0000;
	localparam logic        FLAG_RESET   = 1'b0;
	localparam logic [15:0] ADDR_STEP    = 16'h0001;

	// operation codes presented on op_code
	typedef enum logic [2:0] {
		AOX_OP_WORD_OR      = 3'h0,
		AOX_OP_DOUBLE_OR    = 3'h1,
		AOX_OP_RANGE_OR     = 3'h2,
		AOX_OP_STACK_OR     = 3'h3,
		AOX_OP_WORD_XOR     = 3'h4,
		AOX_OP_DOUBLE_XOR   = 3'h5,
		AOX_OP_PUSH         = 3'h6,
		AOX_OP_LOAD         = 3'h7
	} aox_op_type;

	// operand source for memory-based operations
	typedef enum logic [1:0] {
		AOX_SRC_DIRECT   = 2'h0,
		AOX_SRC_POINTER  = 2'h1,
		AOX_SRC_CONSTANT = 2'h2
	} aox_src_type;
endpackage

// File: verilog/aox_bit_gather.sv
// bit gatherer: masks a run of discrete bits down to its length
`timescale 1ns/100ps
module aox_bit_gather #(
	parameter int WIDTH = 32
) (
	input  wire logic [WIDTH-1:0] bits_in,
	input  wire logic [5:0]       run_len,
	output logic      [WIDTH-1:0] bits_out
);
	import aox_pkg::*;

	// keep bits below run_len, clear the rest
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_mask
			assign bits_out[g] = bits_in[g] & (6'(g) < run_len);
		end
	endgenerate
endmodule // aox_bit_gather

// File: verilog/aox_core.sv
// accumulator or/xor datapath with accumulator stack and status flags
//
// Contract
// - word OR: low 16 bits with memory word
// - double OR: 32 bits with pair or constant
// - range OR over one to thirty-two bits
// - range OR takes start location and count
// - stack OR: accumulator with stack top
// - stack OR pops, entries move up one
// - word XOR: low 16 bits with word
// - double XOR: 32 bits with pair/constant
// - zero flag set when result zero
// - double/stack: negative flag from msb
// - range OR also drives negative flag
// - word OR reports zero result
// - untouched flags keep their value
`timescale 1ns/100ps
module aox_core #(
	parameter int DEPTH = aox_pkg::STACK_DEPTH
) (
	input  wire logic                       clk_sys,
	input  wire logic                       rst,
	input  wire logic                       op_valid,
	input  wire aox_pkg::aox_op_type        op_code,
	input  wire aox_pkg::aox_src_type       op_src,
	input  wire logic [aox_pkg::ADDR_W-1:0] op_addr,
	input  wire logic [aox_pkg::ACC_W-1:0]  op_const,
	input  wire logic [5:0]                 op_count,
	output logic                            op_ready,
	output logic                            op_done,
	output logic                            mem_rd,
	output logic [aox_pkg::ADDR_W-1:0]      mem_addr,
	input  wire logic [aox_pkg::WORD_W-1:0] mem_rdata,
	output logic                            bit_rd,
	output logic [aox_pkg::ADDR_W-1:0]      bit_start,
	input  wire logic [aox_pkg::ACC_W-1:0]  bit_rdata,
	output logic [aox_pkg::ACC_W-1:0]       acc,
	output logic                            zero_result_flag,
	output logic                            negative_result_flag,
	output logic                            range_error
);
	import aox_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE, ST_PTR, ST_LO, ST_HI, ST_BITS, ST_EXEC
	} aox_state_type;

	// ==========================================
	// sequencing state
	aox_state_type            state_q, state_d;
	aox_op_type               op_q, op_d;
	logic [ADDR_W-1:0]        addr_q, addr_d;
	logic [ACC_W-1:0]         opnd_q, opnd_d;
	logic [5:0]               cnt_q, cnt_d;
	logic                     rd_q, rd_d, brd_q, brd_d, done_q, done_d, err_q, err_d;
	logic [ACC_W-1:0]         acc_q, acc_d;
	logic                     zf_q, zf_d, nf_q, nf_d;
	logic [ACC_W-1:0]         stk_q [DEPTH];
	logic [ACC_W-1:0]         stk_d [DEPTH];
	logic [ACC_W-1:0]         gathered;
	logic [ACC_W-1:0]         res;
	logic                     rdy_q, rdy_d;

	aox_bit_gather #(.WIDTH(ACC_W)) u_gather (
		.bits_in  (bit_rdata),
		.run_len  (cnt_q),
		.bits_out (gathered)
	);

	function automatic logic is_double(input aox_op_type o);
		return (o == AOX_OP_DOUBLE_OR) || (o == AOX_OP_DOUBLE_XOR);
	endfunction

	always_comb begin
		state_d = state_q;
		op_d    = op_q;
		addr_d  = addr_q;
		opnd_d  = opnd_q;
		cnt_d   = cnt_q;
		rd_d    = 1'b0;
		brd_d   = 1'b0;
		done_d  = 1'b0;
		err_d   = err_q;
		acc_d   = acc_q;
		zf_d    = zf_q;
		nf_d    = nf_q;
		stk_d   = stk_q;
		res     = acc_q;
		case (state_q)
			ST_IDLE: begin
				// a request counts only while ready is shown
				if (op_valid && rdy_q) begin
					op_d   = op_code;
					addr_d = op_addr;
					cnt_d  = op_count;
					opnd_d = op_const;
					err_d  = 1'b0;
					case (op_code)
						AOX_OP_STACK_OR, AOX_OP_PUSH, AOX_OP_LOAD: state_d = ST_EXEC;
						AOX_OP_RANGE_OR: begin
							if (op_count < RANGE_MIN || op_count > RANGE_MAX) begin
								err_d  = 1'b1;
								done_d = 1'b1;
							end else begin
								brd_d   = 1'b1;
								state_d = ST_BITS;
							end
						end
						default: begin
							if (op_src == AOX_SRC_CONSTANT && is_double(op_code)) begin
								state_d = ST_EXEC;
							end else begin
								rd_d    = 1'b1;
								state_d = (op_src == AOX_SRC_POINTER) ? ST_PTR : ST_LO;
							end
						end
					endcase
				end
			end
			ST_PTR: begin
				addr_d  = mem_rdata;
				rd_d    = 1'b1;
				state_d = ST_LO;
			end
			ST_LO: begin
				opnd_d = {16'h0000, mem_rdata};
				if (is_double(op_q)) begin
					addr_d  = addr_q + ADDR_STEP;
					rd_d    = 1'b1;
					state_d = ST_HI;
				end else begin
					state_d = ST_EXEC;
				end
			end
			ST_HI: begin
				opnd_d  = {mem_rdata, opnd_q[15:0]};
				state_d = ST_EXEC;
			end
			ST_BITS: begin
				opnd_d  = gathered;
				state_d = ST_EXEC;
			end
			ST_EXEC: begin
				done_d  = 1'b1;
				state_d = ST_IDLE;
				case (op_q)
					AOX_OP_WORD_OR: begin
						res  = {acc_q[31:16], acc_q[15:0] | opnd_q[15:0]};
						zf_d = (res == 32'h0000_0000);
					end
					AOX_OP_WORD_XOR: begin
						res  = {acc_q[31:16], acc_q[15:0] ^ opnd_q[15:0]};
						zf_d = (res == 32'h0000_0000);
					end
					AOX_OP_DOUBLE_OR, AOX_OP_RANGE_OR: begin
						res  = acc_q | opnd_q;
						zf_d = (res == 32'h0000_0000);
						nf_d = res[ACC_W-1];
					end
					AOX_OP_DOUBLE_XOR: begin
						res  = acc_q ^ opnd_q;
						zf_d = (res == 32'h0000_0000);
						nf_d = res[ACC_W-1];
					end
					AOX_OP_STACK_OR: begin
						res  = acc_q | stk_q[0];
						zf_d = (res == 32'h0000_0000);
						nf_d = res[ACC_W-1];
						for (int i = 0; i < DEPTH - 1; i++) begin
							stk_d[i] = stk_q[i+1];
						end
						stk_d[DEPTH-1] = ACC_RESET;
					end
					AOX_OP_PUSH: begin
						// push current accumulator, load constant
						for (int i = DEPTH - 1; i > 0; i--) begin
							stk_d[i] = stk_q[i-1];
						end
						stk_d[0] = acc_q;
						res      = opnd_q;
					end
					default: res = opnd_q; // load constant, flags untouched
				endcase
				acc_d = res;
			end
			default: state_d = ST_IDLE;
		endcase
		// ready again as soon as the machine returns to idle
		rdy_d = (state_d == ST_IDLE);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= ST_IDLE;
			op_q    <= AOX_OP_LOAD;
			addr_q  <= 16'h0000;
			opnd_q  <= ACC_RESET;
			cnt_q   <= 6'h00;
			rd_q    <= 1'b0;
			brd_q   <= 1'b0;
			done_q  <= 1'b0;
			err_q   <= 1'b0;
			acc_q   <= ACC_RESET;
			zf_q    <= FLAG_RESET;
			nf_q    <= FLAG_RESET;
			rdy_q   <= 1'b0;
			for (int i = 0; i < DEPTH; i++) begin
				stk_q[i] <= ACC_RESET;
			end
		end else begin
			state_q <= state_d;
			op_q    <= op_d;
			addr_q  <= addr_d;
			opnd_q  <= opnd_d;
			cnt_q   <= cnt_d;
			rd_q    <= rd_d;
			brd_q   <= brd_d;
			done_q  <= done_d;
			err_q   <= err_d;
			acc_q   <= acc_d;
			zf_q    <= zf_d;
			nf_q    <= nf_d;
			stk_q   <= stk_d;
			rdy_q   <= rdy_d;
		end
	end

	// ==========================================
	// outputs
	assign op_ready             = rdy_q;
	assign op_done              = done_q;
	assign mem_rd               = rd_q;
	assign mem_addr             = addr_q;
	assign bit_rd               = brd_q;
	assign bit_start            = addr_q;
	assign acc                  = acc_q;
	assign zero_result_flag     = zf_q;
	assign negative_result_flag = nf_q;
	assign range_error          = err_q;

	// ==========================================
	// assertions
	word_upper_kept_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == ST_EXEC && (op_q == AOX_OP_WORD_OR || op_q == AOX_OP_WORD_XOR))
		|=> acc_q[31:16] == $past(acc_q[31:16]))
		else $error("word op changed upper accumulator half");
	zero_flag_tracks_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == ST_EXEC && op_q inside {AOX_OP_WORD_OR, AOX_OP_WORD_XOR,
		AOX_OP_DOUBLE_OR, AOX_OP_DOUBLE_XOR, AOX_OP_RANGE_OR, AOX_OP_STACK_OR})
		|=> zf_q == (acc_q == 32'h0000_0000))
		else $error("zero flag disagrees with result");
	neg_flag_tracks_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == ST_EXEC && op_q inside {AOX_OP_DOUBLE_OR, AOX_OP_DOUBLE_XOR,
		AOX_OP_RANGE_OR, AOX_OP_STACK_OR}) |=> nf_q == acc_q[31])
		else $error("negative flag disagrees with msb");
	word_neg_kept_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == ST_EXEC && op_q == AOX_OP_WORD_OR) |=> $stable(nf_q))
		else $error("word or touched negative flag");
	stack_or_result_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == ST_EXEC && op_q == AOX_OP_STACK_OR)
		|=> acc_q == ($past(acc_q) | $past(stk_q[0])))
		else $error("stack or result wrong");
	stack_pop_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == ST_EXEC && op_q == AOX_OP_STACK_OR) |=> stk_q[0] == $past(stk_q[1]))
		else $error("stack did not move up");
	double_xor_result_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == ST_EXEC && op_q == AOX_OP_DOUBLE_XOR)
		|=> acc_q == ($past(acc_q) ^ $past(opnd_q)))
		else $error("double xor result wrong");
	pointer_fetch_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == ST_PTR) |=> mem_rd && mem_addr == $past(mem_rdata) && state_q == ST_LO)
		else $error("pointer not followed");
	range_len_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == ST_BITS) |-> cnt_q >= RANGE_MIN && cnt_q <= RANGE_MAX)
		else $error("range length out of bounds");
endmodule // aox_core

// File: tb/tb_top.sv
// testbench: corner and random checks of the accumulator or/xor datapath
`timescale 1ns/100ps
module tb_top;
	import aox_pkg::*;
	logic        clk_sys, rst, op_valid, op_ready, op_done, mem_rd, bit_rd, range_error;
	logic        zero_result_flag, negative_result_flag, m_z, m_n, m_e;
	aox_op_type  op_code;
	aox_src_type op_src;
	logic [15:0] op_addr, mem_addr, mem_rdata, bit_start;
	logic [31:0] op_const, bit_rdata, acc, m_acc, seed;
	logic [31:0] m_stk [8];
	logic [5:0]  op_count;
	int          error_cnt, total_checks;
	aox_core i_aox_core (.clk_sys(clk_sys), .rst(rst), .op_valid(op_valid), .op_code(op_code),
		.op_src(op_src), .op_addr(op_addr), .op_const(op_const), .op_count(op_count),
		.op_ready(op_ready), .op_done(op_done), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.mem_rdata(mem_rdata), .bit_rd(bit_rd), .bit_start(bit_start), .bit_rdata(bit_rdata),
		.acc(acc), .zero_result_flag(zero_result_flag),
		.negative_result_flag(negative_result_flag), .range_error(range_error));
	// ==========
	// helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// words of the top address page read as zero
	function automatic logic [15:0] mem_fn(input logic [15:0] a);
		return (a[15:12] == 4'hF) ? 16'h0000 : (a * 16'h9E37) ^ 16'h3C5A;
	endfunction
	function automatic logic [31:0] bit_fn(input logic [15:0] s);
		return {s * 16'h7A31, ~s};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic report_and_stop();
		if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic zn();
		m_z = (m_acc == 32'h0000_0000);
		m_n = m_acc[31];
	endtask
	task automatic do_op(input aox_op_type c, input aox_src_type s, input logic [15:0] a,
		input logic [31:0] k, input logic [5:0] n);
		logic [31:0] v;
		logic [15:0] p;
		int          lat, t;
		p = (s == AOX_SRC_POINTER) ? mem_fn(a) : a;
		v = (s == AOX_SRC_CONSTANT) ? k : {mem_fn(p + 16'h0001), mem_fn(p)};
		lat = (s == AOX_SRC_POINTER) ? 1 : 0;
		m_e = 1'b0;
		case (c)
			AOX_OP_WORD_OR, AOX_OP_WORD_XOR: begin
				m_acc[15:0] = c[2] ? m_acc[15:0] ^ v[15:0] : m_acc[15:0] | v[15:0];
				m_z = (m_acc == 32'h0000_0000);
				lat += 3;
			end
			AOX_OP_DOUBLE_OR, AOX_OP_DOUBLE_XOR: begin
				m_acc = c[2] ? m_acc ^ v : m_acc | v;
				zn();
				lat += (s == AOX_SRC_CONSTANT) ? 2 : 4;
			end
			AOX_OP_RANGE_OR: begin
				if (n == 6'h00 || n > 6'h20) begin
					m_e = 1'b1;
					lat = 1;
				end else begin
					m_acc |= bit_fn(a) & ((n == 6'h20) ? 32'hFFFF_FFFF : (32'h1 << n) - 1);
					zn();
					lat = 3;
				end
			end
			AOX_OP_STACK_OR: begin
				m_acc |= m_stk[0];
				for (int i = 0; i < 7; i++) m_stk[i] = m_stk[i + 1];
				m_stk[7] = 32'h0000_0000;
				zn();
				lat = 2;
			end
			AOX_OP_PUSH: begin
				for (int i = 7; i > 0; i--) m_stk[i] = m_stk[i - 1];
				m_stk[0] = m_acc;
				m_acc = k;
				lat = 2;
			end
			default: begin
				m_acc = k;
				lat = 2;
			end
		endcase
		// one negedge first, so op_valid never falls and rises in one step
		t = 0;
		do begin
			@(negedge clk_sys);
			t++;
		end while (op_ready !== 1'b1 && t < 50);
		op_valid = 1'b1;
		op_code = c;
		op_src = s;
		op_addr = a;
		op_const = k;
		op_count = n;
		@(negedge clk_sys);
		op_valid = 1'b0;
		t = 1;
		while (op_done !== 1'b1 && t < 50) begin
			@(negedge clk_sys);
			t++;
		end
		chk("latency", lat, t);
		chk("acc", m_acc, acc);
		chk("flags", {m_z, m_n}, {zero_result_flag, negative_result_flag});
		chk("range_error", m_e, range_error);
	endtask
	// ==========
	// clock, memories, watchdog
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(negedge clk_sys) begin
		mem_rdata <= mem_rd ? mem_fn(mem_addr) : ~mem_fn(mem_addr);
		bit_rdata <= bit_rd ? bit_fn(bit_start) : ~bit_fn(bit_start);
	end
	initial begin
		#400000;
		error_cnt++;
		report_and_stop();
	end
	// ==========
	// sequence
	initial begin
		logic [31:0] r;
		aox_op_type  c;
		aox_src_type s;
		op_valid = 1'b0;
		op_code = AOX_OP_LOAD;
		op_src = AOX_SRC_DIRECT;
		{op_addr, op_const, op_count} = '1;
		{error_cnt, total_checks} = '0;
		seed = 32'h9904_6BF5;
		// second pass starts with a reset in mid-run
		for (int pass = 0; pass < 2; pass++) begin
			rst = 1'b1;
			repeat (2) @(negedge clk_sys);
			rst = 1'b0;
			{m_acc, m_z, m_n, m_e} = '0;
			foreach (m_stk[i]) m_stk[i] = 32'h0000_0000;
			chk("reset", 32'h0000_0000,
				{acc[27:0], op_ready, op_done, zero_result_flag, negative_result_flag});
			do_op(AOX_OP_STACK_OR, AOX_SRC_DIRECT, '0, '0, '0);
			do_op(AOX_OP_WORD_OR, AOX_SRC_DIRECT, 16'hF000, '0, '0);
			do_op(AOX_OP_DOUBLE_OR, AOX_SRC_CONSTANT, '0, 32'h8000_0000, '0);
			do_op(AOX_OP_WORD_XOR, AOX_SRC_POINTER, 16'h0123, '0, '0);
			do_op(AOX_OP_LOAD, AOX_SRC_DIRECT, '0, 32'hFFFF_0000, '0);
			do_op(AOX_OP_WORD_XOR, AOX_SRC_DIRECT, 16'hF001, '0, '0);
			do_op(AOX_OP_DOUBLE_XOR, AOX_SRC_CONSTANT, '0, 32'hFFFF_0000, '0);
			do_op(AOX_OP_DOUBLE_XOR, AOX_SRC_POINTER, 16'h0040, '0, '0);
			foreach (m_stk[i]) begin
				do_op(AOX_OP_RANGE_OR, AOX_SRC_DIRECT, 16'(rnd()), '0, 6'(i * 6 - 6));
			end
			do_op(AOX_OP_RANGE_OR, AOX_SRC_DIRECT, 16'h8001, '0, 6'h20);
			for (int i = 0; i < 9; i++) do_op(AOX_OP_PUSH, AOX_SRC_DIRECT, '0, i + 1, '0);
			for (int i = 0; i < 9; i++) begin
				do_op(AOX_OP_STACK_OR, AOX_SRC_DIRECT, '0, '0, '0);
			end
			for (int i = 0; i < 400; i++) begin
				r = rnd();
				c = aox_op_type'(r[2:0]);
				s = aox_src_type'(r[4:3] % 3);
				// constants only for the double ops (codes 1 and 5)
				if (s == AOX_SRC_CONSTANT && r[1:0] != 2'h1) begin
					s = AOX_SRC_POINTER;
				end
				do_op(c, s, r[31:16], rnd(), 6'(r[13:8] % 34));
			end
		end
		report_and_stop();
	end
endmodule // tb_top
